// ---- hdl/bus_event_detect.v ----
/*
 Pin conditioner for the two-wire bus: three-stage synchronisers, a level
 filter that accepts a change once the second and third stage agree, and
 one-cycle pulses for clock edges and for START and STOP conditions.
 Assumes free-running mclk; ce low freezes every flop.
*/
`timescale 1ns/1ps
module bus_event_detect (
   input wire mclk,
   input wire rst_b,
   input wire ce,
   input wire scl_pin,
   input wire sda_pin,
   output reg scl_level,
   output reg sda_level,
   output reg scl_rise,
   output reg scl_fall,
   output reg start_seen,
   output reg stop_seen
);
   reg scl_s1, scl_s2, scl_s3;
   reg sda_s1, sda_s2, sda_s3;
   wire next_scl;
   wire next_sda;

   assign next_scl = (scl_s2 == scl_s3) ? scl_s3 : scl_level;
   assign next_sda = (sda_s2 == sda_s3) ? sda_s3 : sda_level;

   always @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         scl_s1 <= 1'b1;
         scl_s2 <= 1'b1;
         scl_s3 <= 1'b1;
         sda_s1 <= 1'b1;
         sda_s2 <= 1'b1;
         sda_s3 <= 1'b1;
         scl_level <= 1'b1;
         sda_level <= 1'b1;
         scl_rise <= 1'b0;
         scl_fall <= 1'b0;
         start_seen <= 1'b0;
         stop_seen <= 1'b0;
      end else if (ce) begin
         scl_s1 <= scl_pin;
         scl_s2 <= scl_s1;
         scl_s3 <= scl_s2;
         sda_s1 <= sda_pin;
         sda_s2 <= sda_s1;
         sda_s3 <= sda_s2;
         scl_level <= next_scl;
         sda_level <= next_sda;
         scl_rise <= !scl_level && next_scl;
         scl_fall <= scl_level && !next_scl;
         // A data change only counts while the clock stays high on both sides.
         start_seen <= scl_level && next_scl && sda_level && !next_sda;
         stop_seen <= scl_level && next_scl && !sda_level && next_sda;
      end
   end
endmodule

// ---- hdl/i2c_status_code_reporting.v ----
/*
 Two-wire bus status reporting with an AXI4-Lite register slave: a slave-side
 bus tracker, the state code register with its event flag, the data byte
 register, bus error detection and a masked interrupt.
 Assumes one clock mclk, single outstanding AXI transfers, and an external
 open-drain wire resolved from sda_oe (pulls low while high).
*/
`timescale 1ns/1ps
`include "i2c_status_map.vh"
module i2c_status_code_reporting (
   input wire mclk,
   input wire rst_b,
   input wire ce,
   input wire [`AXI_AW-1:0] awaddr,
   input wire awvalid,
   output reg awready,
   input wire [31:0] wdata,
   input wire [3:0] wstrb,
   input wire wvalid,
   output reg wready,
   output reg [1:0] bresp,
   output reg bvalid,
   input wire bready,
   input wire [`AXI_AW-1:0] araddr,
   input wire arvalid,
   output reg arready,
   output reg [31:0] rdata,
   output reg [1:0] rresp,
   output reg rvalid,
   input wire rready,
   input wire scl_in,
   input wire sda_in,
   output reg sda_out,
   output reg sda_oe,
   output reg irq
);
   localparam [4:0] ST_IDLE = 5'h01;
   localparam [4:0] ST_ADDR = 5'h02;
   localparam [4:0] ST_RX = 5'h04;
   localparam [4:0] ST_TX = 5'h08;
   localparam [4:0] ST_SKIP = 5'h10;
   localparam integer HOLD_INT = `HOLD_CLKS;
   localparam [2:0] HOLD_LOAD = HOLD_INT[2:0];

   function hit;
      input [`AXI_AW-1:0] addr;
      input [9:0] idx;
      begin
         hit = (addr[`AXI_AW-1:2] == idx);
      end
   endfunction

   function code_valid;
      input [4:0] c;
      reg [31:0] m;
      begin
         m = `VALID_CODE_MASK;
         code_valid = m[c];
      end
   endfunction

   wire sda_level, scl_rise, scl_fall, start_seen, stop_seen;

   bus_event_detect pins (
      .mclk(mclk),
      .rst_b(rst_b),
      .ce(ce),
      .scl_pin(scl_in),
      .sda_pin(sda_in),
      .scl_level(),
      .sda_level(sda_level),
      .scl_rise(scl_rise),
      .scl_fall(scl_fall),
      .start_seen(start_seen),
      .stop_seen(stop_seen)
   );

   reg [`AXI_AW-1:0] aw_addr;
   reg aw_full;
   reg [31:0] w_data;
   reg [3:0] w_strb;
   reg w_full;
   reg enable, ack_en;
   reg [6:0] own_addr;
   reg [7:0] byte_buf;
   reg [`IRQ_W-1:0] irq_st, irq_mask;
   reg [4:0] code, pend_code;
   reg flag, pend_v;
   reg [2:0] hold;
   reg [4:0] state;
   reg [3:0] cnt;
   reg [7:0] shift, tx_shift;
   reg ack_sent;
   reg tr_evt, rx_load;
   reg [4:0] tr_code;

   wire wr_go = aw_full && w_full && !bvalid;
   wire flag_clr = wr_go && hit(aw_addr, `IDX_FLAG) && w_strb[0] && w_data[`FLAG_BIT];
   wire evt_ok = tr_evt && code_valid(tr_code) && (tr_code != `CODE_IDLE);

   reg [4:0] next_code, next_pend_code;
   reg [2:0] next_hold;
   reg next_flag, next_pend_v, ovr;
   always @* begin
      next_code = code;
      next_flag = flag;
      next_hold = hold;
      next_pend_v = pend_v;
      next_pend_code = pend_code;
      ovr = 1'b0;
      if (hold != 3'h0) begin
         next_hold = hold - 3'h1;
         if (hold == 3'h1 && !pend_v) begin
            next_code = `CODE_IDLE;
         end
      end
      if (flag && flag_clr) begin
         next_flag = 1'b0;
         next_hold = HOLD_LOAD;
      end
      if (!flag && hold == 3'h0) begin
         if (pend_v) begin
            next_code = pend_code;
            next_flag = 1'b1;
            next_pend_v = evt_ok;
            next_pend_code = tr_code;
         end else if (evt_ok) begin
            // Code and flag load on the same edge, so the code is valid at once.
            next_code = tr_code;
            next_flag = 1'b1;
         end
      end else if (evt_ok) begin
         // Only one state can wait; a pending bus error is never overwritten.
         ovr = pend_v;
         next_pend_v = 1'b1;
         if (!pend_v || pend_code != `CODE_BERR) begin
            next_pend_code = tr_code;
         end
      end
   end

   always @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         code <= `CODE_IDLE;
         flag <= 1'b0;
         hold <= 3'h0;
         pend_v <= 1'b0;
         pend_code <= `CODE_IDLE;
      end else if (ce) begin
         code <= next_code;
         flag <= next_flag;
         hold <= next_hold;
         pend_v <= next_pend_v;
         pend_code <= next_pend_code;
      end
   end

   // Bus tracker. There is no clock stretching, so software must have the
   // next byte to send in the data register before the acknowledge ends.
   always @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         state <= ST_IDLE;
         cnt <= 4'h0;
         shift <= `RST_BYTE;
         tx_shift <= `RST_BYTE;
         ack_sent <= 1'b0;
         sda_oe <= 1'b0;
         sda_out <= 1'b0;
         tr_evt <= 1'b0;
         tr_code <= `CODE_IDLE;
         rx_load <= 1'b0;
      end else if (ce) begin
         tr_evt <= 1'b0;
         rx_load <= 1'b0;
         if (!enable) begin
            state <= ST_IDLE;
            cnt <= 4'h0;
            sda_oe <= 1'b0;
         end else if (start_seen || stop_seen) begin
            sda_oe <= 1'b0;
            cnt <= 4'h0;
            if (state != ST_IDLE && cnt >= `LATE_BIT) begin
               tr_evt <= 1'b1;
               tr_code <= `CODE_BERR;
               state <= ST_IDLE;
            end else begin
               if (state == ST_RX || state == ST_TX) begin
                  tr_evt <= 1'b1;
                  tr_code <= `CODE_STOP;
               end
               state <= start_seen ? ST_ADDR : ST_IDLE;
            end
         end else if (scl_rise && state != ST_IDLE) begin
            cnt <= cnt + 4'h1;
            if (cnt < `BYTE_BITS) begin
               shift <= {shift[6:0], sda_level};
            end
            if (cnt == `BYTE_BITS) begin
               case (state)
                  ST_ADDR: begin
                     if (shift[7:1] == own_addr) begin
                        tr_evt <= 1'b1;
                        tr_code <= shift[0] ? `CODE_ADDR_R : `CODE_ADDR_W;
                        state <= shift[0] ? ST_TX : ST_RX;
                     end else begin
                        state <= ST_SKIP;
                     end
                  end
                  ST_RX: begin
                     rx_load <= 1'b1;
                     tr_evt <= 1'b1;
                     tr_code <= ack_sent ? `CODE_RX_ACK : `CODE_RX_NACK;
                     if (!ack_sent) begin
                        state <= ST_SKIP;
                     end
                  end
                  ST_TX: begin
                     tr_evt <= 1'b1;
                     tr_code <= sda_level ? `CODE_TX_NACK : `CODE_TX_ACK;
                     if (sda_level) begin
                        state <= ST_SKIP;
                     end
                  end
                  default: begin
                  end
               endcase
            end
         end else if (scl_fall && state != ST_IDLE) begin
            if (cnt == `BYTE_BITS) begin
               ack_sent <= (state == ST_RX) && ack_en;
               sda_oe <= ((state == ST_ADDR) && (shift[7:1] == own_addr)) ||
                         ((state == ST_RX) && ack_en);
            end else if (cnt == `ACK_BIT) begin
               cnt <= 4'h0;
               sda_oe <= (state == ST_TX) && !byte_buf[7];
               tx_shift <= {byte_buf[6:0], 1'b0};
            end else if (state == ST_TX && cnt != 4'h0) begin
               sda_oe <= !tx_shift[7];
               tx_shift <= {tx_shift[6:0], 1'b0};
            end
         end
      end
   end

   // Software registers. A byte received on the bus wins over a software
   // write in the same cycle so that no received data is lost.
   wire [`IRQ_W-1:0] irq_set;
   assign irq_set[`IRQ_STATE] = next_flag && !flag;
   assign irq_set[`IRQ_BERR] = evt_ok && (tr_code == `CODE_BERR);
   assign irq_set[`IRQ_OVR] = ovr;
   wire [`IRQ_W-1:0] irq_clr = (wr_go && hit(aw_addr, `IDX_IRQ_ST) && w_strb[0]) ?
                               w_data[`IRQ_W-1:0] : {`IRQ_W{1'b0}};

   always @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         enable <= 1'b0;
         ack_en <= 1'b0;
         own_addr <= `RST_ADDR;
         byte_buf <= `RST_BYTE;
         irq_st <= {`IRQ_W{1'b0}};
         irq_mask <= {`IRQ_W{1'b0}};
         irq <= 1'b0;
      end else if (ce) begin
         irq_st <= (irq_st & ~irq_clr) | irq_set;
         irq <= |(irq_st & irq_mask);
         if (rx_load) begin
            byte_buf <= shift;
         end else if (wr_go && hit(aw_addr, `IDX_DATA) && w_strb[0]) begin
            byte_buf <= w_data[7:0];
         end
         if (wr_go && hit(aw_addr, `IDX_CTRL)) begin
            if (w_strb[0]) begin
               enable <= w_data[`CTRL_EN];
               ack_en <= w_data[`CTRL_ACK];
            end
            if (w_strb[1]) begin
               own_addr <= w_data[`CTRL_ADDR_MSB:`CTRL_ADDR_LSB];
            end
         end
         if (wr_go && hit(aw_addr, `IDX_IRQ_MASK) && w_strb[0]) begin
            irq_mask <= w_data[`IRQ_W-1:0];
         end
      end
   end

   function wr_ok;
      input [`AXI_AW-1:0] a;
      begin
         wr_ok = hit(a, `IDX_DATA) || hit(a, `IDX_CTRL) || hit(a, `IDX_FLAG) ||
                 hit(a, `IDX_IRQ_ST) || hit(a, `IDX_IRQ_MASK);
      end
   endfunction

   reg [31:0] rd_val;
   reg rd_ok;
   always @* begin
      rd_val = 32'h0;
      rd_ok = 1'b1;
      if (hit(araddr, `IDX_CODE)) begin
         rd_val[7:0] = {code, `LOW_ZERO};
      end else if (hit(araddr, `IDX_DATA)) begin
         rd_val[7:0] = byte_buf;
      end else if (hit(araddr, `IDX_CTRL)) begin
         rd_val[`CTRL_EN] = enable;
         rd_val[`CTRL_ACK] = ack_en;
         rd_val[`CTRL_ADDR_MSB:`CTRL_ADDR_LSB] = own_addr;
      end else if (hit(araddr, `IDX_FLAG)) begin
         rd_val[`FLAG_BIT] = flag;
      end else if (hit(araddr, `IDX_IRQ_ST)) begin
         rd_val[`IRQ_W-1:0] = irq_st;
      end else if (hit(araddr, `IDX_IRQ_MASK)) begin
         rd_val[`IRQ_W-1:0] = irq_mask;
      end else begin
         rd_ok = 1'b0;
      end
   end

   always @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         awready <= 1'b1;
         wready <= 1'b1;
         aw_full <= 1'b0;
         w_full <= 1'b0;
         aw_addr <= {`AXI_AW{1'b0}};
         w_data <= 32'h0;
         w_strb <= 4'h0;
         bvalid <= 1'b0;
         bresp <= `RESP_OKAY;
         arready <= 1'b1;
         rvalid <= 1'b0;
         rdata <= 32'h0;
         rresp <= `RESP_OKAY;
      end else if (ce) begin
         if (awvalid && awready) begin
            aw_addr <= awaddr;
            aw_full <= 1'b1;
            awready <= 1'b0;
         end
         if (wvalid && wready) begin
            w_data <= wdata;
            w_strb <= wstrb;
            w_full <= 1'b1;
            wready <= 1'b0;
         end
         if (wr_go) begin
            aw_full <= 1'b0;
            w_full <= 1'b0;
            bvalid <= 1'b1;
            bresp <= wr_ok(aw_addr) ? `RESP_OKAY : `RESP_SLVERR;
         end
         if (bvalid && bready) begin
            bvalid <= 1'b0;
            awready <= 1'b1;
            wready <= 1'b1;
         end
         if (arvalid && arready) begin
            arready <= 1'b0;
            rvalid <= 1'b1;
            rdata <= rd_val;
            rresp <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
         end
         if (rvalid && rready) begin
            rvalid <= 1'b0;
            arready <= 1'b1;
         end
      end
   end
endmodule

// ---- hdl/i2c_status_map.vh ----
/*
 Register indices, field positions, state codes and timing figures for the
 two-wire status block. Included by the status block, the test bench and the checker by its bare name.
*/
`ifndef I2C_STATUS_MAP_VH
`define I2C_STATUS_MAP_VH
`define AXI_AW 12
`define IDX_DATA 10'h0BC
`define IDX_CODE 10'h0BD
`define IDX_CTRL 10'h0C0
`define IDX_FLAG 10'h0C1
`define IDX_IRQ_ST 10'h0C2
`define IDX_IRQ_MASK 10'h0C3
`define CTRL_EN 0
`define CTRL_ACK 1
`define CTRL_ADDR_LSB 8
`define CTRL_ADDR_MSB 14
`define FLAG_BIT 0
`define IRQ_STATE 0
`define IRQ_BERR 1
`define IRQ_OVR 2
`define IRQ_W 3
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`define LOW_ZERO 3'h0
`define CODE_BERR 5'h00
`define CODE_ADDR_W 5'h0C
`define CODE_RX_ACK 5'h10
`define CODE_RX_NACK 5'h11
`define CODE_STOP 5'h14
`define CODE_ADDR_R 5'h15
`define CODE_TX_ACK 5'h17
`define CODE_TX_NACK 5'h18
`define CODE_IDLE 5'h1F
`define VALID_CODE_MASK 32'h81BBBFFF
`define BYTE_BITS 4'h8
`define ACK_BIT 4'h9
`define LATE_BIT 4'h2
`define RST_BYTE 8'h00
`define RST_ADDR 7'h00
`define CLK_PERIOD_NS 20
`define MACHINE_CYCLE_NS 80
`define HOLD_CLKS ((`MACHINE_CYCLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// ---- testbench/i2c_bus_model.sv ----
/*
 Master on the two-wire bus that addresses the block.
 Assumes a pull-up on SDA resolved outside; SCL idles high between frames.
*/
`timescale 1ns/1ps
module i2c_bus_model (
   input wire mclk,
   input wire sda_line,
   output reg scl,
   output reg sda_low
);
   initial begin
      scl = 1'b1;
      sda_low = 1'b0;
   end
   // Eight clocks a phase leaves margin over the pin filter latency.
   task half;
      repeat (8) @(posedge mclk);
   endtask
   task send_start;
      begin
         sda_low <= 1'b0;
         half;
         scl <= 1'b1;
         half;
         sda_low <= 1'b1;
         half;
         scl <= 1'b0;
         half;
      end
   endtask
   task send_bit(input b);
      begin
         sda_low <= ~b;
         half;
         scl <= 1'b1;
         half;
         scl <= 1'b0;
         half;
      end
   endtask
   task send_byte(input [7:0] d, output ack);
      integer i;
      begin
         for (i = 7; i >= 0; i = i - 1) begin
            send_bit(d[i]);
         end
         sda_low <= 1'b0;
         half;
         scl <= 1'b1;
         half;
         ack = ~sda_line;
         scl <= 1'b0;
         half;
      end
   endtask
   // The acknowledge is left driven so that a following stop needs no extra release.
   task recv_byte(input ack_bit, output [7:0] d);
      integer i;
      begin
         for (i = 7; i >= 0; i = i - 1) begin
            sda_low <= 1'b0;
            half;
            scl <= 1'b1;
            half;
            d[i] = sda_line;
            scl <= 1'b0;
            half;
         end
         send_bit(~ack_bit);
      end
   endtask
   task send_stop;
      begin
         sda_low <= 1'b1;
         half;
         scl <= 1'b1;
         half;
         sda_low <= 1'b0;
         half;
      end
   endtask
endmodule

// ---- testbench/i2c_status_code_reporting_test.sv ----
/*
 Self-checking bench: AXI4-Lite master tasks and one task per scenario.
 Assumes the bus model and checker are compiled alongside the design.
*/
`timescale 1ns/1ps
`include "i2c_status_map.vh"
`define CHK(g, e) begin n_tests = n_tests + 1; if ((g) !== (e)) begin \
n_mismatch = n_mismatch + 1; $display("Error at %0t: got %h expected %h", $time, g, e); end end
module i2c_status_code_reporting_test;
   localparam [11:0] a_data = {`IDX_DATA, 2'b00};
   localparam [11:0] a_code = {`IDX_CODE, 2'b00};
   localparam [11:0] a_ctrl = {`IDX_CTRL, 2'b00};
   localparam [11:0] a_flag = {`IDX_FLAG, 2'b00};
   localparam [11:0] a_ist = {`IDX_IRQ_ST, 2'b00};
   localparam [11:0] a_mask = {`IDX_IRQ_MASK, 2'b00};
   reg mclk = 1'b0;
   reg rst_b = 1'b0;
   reg [11:0] awaddr = 12'h0;
   reg awvalid = 1'b0;
   reg [31:0] wdata = 32'h0;
   reg wvalid = 1'b0;
   reg bready = 1'b0;
   reg [11:0] araddr = 12'h0;
   reg arvalid = 1'b0;
   reg rready = 1'b0;
   wire awready, wready, bvalid, arready, rvalid, sda_out, sda_oe, irq, scl, sda_low;
   wire [1:0] bresp;
   wire [1:0] rresp;
   wire [31:0] rdata;
   wire sda_line = ~(sda_low | sda_oe);
   integer n_tests = 0;
   integer n_mismatch = 0;
   reg [31:0] rd;
   reg [1:0] rs;
   reg ack;
   reg [1:0] bs;
   reg [7:0] rx_byte;
   always #10 mclk = ~mclk;
   i2c_status_code_reporting u_dut (.mclk(mclk), .rst_b(rst_b), .ce(1'b1), .awaddr(awaddr),
      .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid),
      .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
      .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
      .rready(rready), .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe),
      .irq(irq));
   i2c_bus_model u_bus (.mclk(mclk), .sda_line(sda_line), .scl(scl), .sda_low(sda_low));
   task finish_test;
      begin
         $display("Comparisons %0d, mismatches %0d", n_tests, n_mismatch);
         if (n_mismatch == 0 && n_tests > 0) begin
            $display("Result: passed");
         end else begin
            $display("Result: failed");
         end
         $finish;
      end
   endtask
   task wr(input [11:0] a, input [31:0] d);
      integer n;
      begin
         n = 0;
         @(posedge mclk);
         awaddr <= a;
         wdata <= d;
         awvalid <= 1'b1;
         wvalid <= 1'b1;
         bready <= 1'b1;
         do begin
            @(posedge mclk);
            n = n + 1;
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
         end while (!bvalid && n < 100);
         bs = bresp;
         bready <= 1'b0;
         if (n >= 100) n_mismatch = n_mismatch + 1;
      end
   endtask
   task rd_reg(input [11:0] a);
      integer n;
      begin
         n = 0;
         @(posedge mclk);
         araddr <= a;
         arvalid <= 1'b1;
         rready <= 1'b1;
         do begin
            @(posedge mclk);
            n = n + 1;
            if (arready) arvalid <= 1'b0;
         end while (!rvalid && n < 100);
         rd = rdata;
         rs = rresp;
         rready <= 1'b0;
         if (n >= 100) n_mismatch = n_mismatch + 1;
      end
   endtask
   task expect_reg(input [11:0] a, input [31:0] e);
      begin
         rd_reg(a);
         `CHK(rd, e)
         `CHK(rs, `RESP_OKAY)
      end
   endtask
   task t_reset;
      begin
         expect_reg(a_code, 32'hF8);
         `CHK(irq, 1'b0)
         `CHK(sda_out, 1'b0)
      end
   endtask
   task t_data_reg;
      begin
         wr(a_data, 32'hC3);
         `CHK(bs, `RESP_OKAY)
         expect_reg(a_data, 32'hC3);
         wr(12'h100, 32'h1);
         `CHK(bs, `RESP_SLVERR)
         rd_reg(12'h100);
         `CHK(rs, `RESP_SLVERR)
         `CHK(rd, 32'h0)
      end
   endtask
   task t_addr_write;
      begin
         wr(a_ctrl, 32'h5003);
         wr(a_mask, 32'h7);
         u_bus.send_start;
         u_bus.send_byte(8'hA0, ack);
         `CHK(ack, 1'b1)
         expect_reg(a_code, 32'h60);
         expect_reg(a_flag, 32'h1);
         `CHK(irq, 1'b1)
         wr(a_flag, 32'h1);
         expect_reg(a_code, 32'h60);
         repeat (10) @(posedge mclk);
         expect_reg(a_code, 32'hF8);
      end
   endtask
   task t_rx_byte;
      begin
         u_bus.send_byte(8'h5A, ack);
         `CHK(ack, 1'b1)
         expect_reg(a_code, 32'h80);
         expect_reg(a_data, 32'h5A);
         wr(a_flag, 32'h1);
         wr(a_ist, 32'h7);
         repeat (4) @(posedge mclk);
         `CHK(irq, 1'b0)
         u_bus.send_stop;
         repeat (10) @(posedge mclk);
         expect_reg(a_code, 32'hA0);
         wr(a_flag, 32'h1);
      end
   endtask
   task t_bus_error;
      begin
         wr(a_mask, 32'h0);
         wr(a_ist, 32'h7);
         u_bus.send_start;
         u_bus.send_bit(1'b1);
         u_bus.send_bit(1'b0);
         u_bus.send_bit(1'b1);
         // A stop three bits into the address byte is out of place.
         u_bus.send_stop;
         repeat (10) @(posedge mclk);
         expect_reg(a_code, 32'h00);
         rd_reg(a_ist);
         `CHK(rd[`IRQ_BERR], 1'b1)
         `CHK(irq, 1'b0)
         wr(a_mask, 32'h2);
         repeat (4) @(posedge mclk);
         `CHK(irq, 1'b1)
         wr(a_ist, 32'h7);
         repeat (4) @(posedge mclk);
         `CHK(irq, 1'b0)
      end
   endtask
   task t_tx_byte;
      begin
         wr(a_flag, 32'h1);
         wr(a_data, 32'h96);
         u_bus.send_start;
         u_bus.send_byte(8'hA1, ack);
         `CHK(ack, 1'b1)
         expect_reg(a_code, 32'hA8);
         wr(a_flag, 32'h1);
         u_bus.recv_byte(1'b1, rx_byte);
         `CHK(rx_byte, 8'h96)
         expect_reg(a_code, 32'hB8);
         wr(a_flag, 32'h1);
         u_bus.send_stop;
         repeat (10) @(posedge mclk);
         expect_reg(a_code, 32'hA0);
      end
   endtask
   initial begin
      #1_000_000;
      n_mismatch = n_mismatch + 1;
      finish_test;
   end
   initial begin
      repeat (10) @(posedge mclk);
      rst_b <= 1'b1;
      t_reset;
      t_data_reg;
      t_addr_write;
      t_rx_byte;
      t_bus_error;
      t_tx_byte;
      finish_test;
   end
endmodule

// ---- testbench/status_checker_asserts.sv ----
/*
 Checker for the status block: AXI handshakes and reads of the state code.
 Assumes it is bound to the top module and the register map header is on the include path.
*/
`timescale 1ns/1ps
`include "i2c_status_map.vh"
module status_checker (
   input wire mclk,
   input wire rst_b,
   input wire awready,
   input wire wready,
   input wire bvalid,
   input wire bready,
   input wire [`AXI_AW-1:0] araddr,
   input wire arvalid,
   input wire arready,
   input wire [31:0] rdata,
   input wire [1:0] rresp,
   input wire rvalid,
   input wire rready
);
   localparam [31:0] valid_codes = `VALID_CODE_MASK;
   reg rd_code;
   always @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         rd_code <= 1'b0;
      end else if (arvalid && arready) begin
         rd_code <= (araddr == {`IDX_CODE, 2'b00});
      end
   end
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_b);
   code_low_zero_a: assert property (
      rvalid && rd_code |-> rdata[2:0] == 3'h0) else $error("Code low bits not zero.");
   code_upper_a: assert property (
      rvalid && rd_code |-> rdata[31:8] == 24'h0) else $error("Code beyond its byte.");
   code_defined_a: assert property (
      rvalid && rd_code |-> valid_codes[rdata[7:3]]) else $error("Undefined code read.");
   read_answer_a: assert property (
      arvalid && arready |=> rvalid && !arready) else $error("Read answer late.");
   read_hold_a: assert property (
      rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp)) else $error("Read moved.");
   read_done_a: assert property (
      rvalid && rready |=> !rvalid && arready) else $error("Read not released.");
   write_hold_a: assert property (
      bvalid && !bready |=> bvalid) else $error("Write response dropped.");
   write_busy_a: assert property (
      bvalid |-> !awready && !wready) else $error("Write taken while busy.");
   cover property (rvalid && rd_code);
   cover property (rvalid && rresp == 2'h2);
   cover property (bvalid && bready);
endmodule
bind i2c_status_code_reporting status_checker u_chk (.mclk(mclk), .rst_b(rst_b),
   .awready(awready), .wready(wready), .bvalid(bvalid), .bready(bready), .araddr(araddr),
   .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
   .rready(rready));
